// *** shared/gofm_pkg.sv ***
// Constants, codes and carriers for the pin output function selector
package gofm_pkg;

	localparam int unsigned NUM_PINS      = 7;
	localparam int unsigned NUM_PORTS     = 2;
	localparam int unsigned REMOTE_PINS   = 4;

	localparam logic [7:0] PIN0_CTL_OFFSET = 8'h10;
	localparam logic [7:0] PIN6_CTL_OFFSET = 8'h16;
	localparam logic [7:0] PIN_CTL_RESET   = 8'h00;

	localparam int unsigned FUNC_MSB  = 7;
	localparam int unsigned FUNC_LSB  = 5;
	localparam int unsigned SRC_MSB   = 4;
	localparam int unsigned SRC_LSB   = 2;
	localparam int unsigned CONST_BIT = 1;
	localparam int unsigned EN_BIT    = 0;

	localparam logic [2:0] SRC_PORT0   = 3'h0;
	localparam logic [2:0] SRC_PORT1   = 3'h1;
	localparam logic [2:0] SRC_DEVICE  = 3'h4;
	localparam logic [2:0] SRC_TXPORT  = 3'h5;

	// Per-port function codes
	localparam logic [2:0] FN_LOCK     = 3'h4;
	localparam logic [2:0] FN_PASS     = 3'h5;
	localparam logic [2:0] FN_FV       = 3'h6;
	localparam logic [2:0] FN_LV       = 3'h7;

	// Device status function codes
	localparam logic [2:0] FN_CONST    = 3'h0;
	localparam logic [2:0] FN_LOCK_OR  = 3'h1;
	localparam logic [2:0] FN_LOCK_AND = 3'h2;
	localparam logic [2:0] FN_PASS_AND = 3'h3;
	localparam logic [2:0] FN_FSYNC    = 3'h4;
	localparam logic [2:0] FN_IRQ_HI   = 3'h5;
	localparam logic [2:0] FN_IRQ_LO   = 3'h6;

	// Transmit port function codes
	localparam logic [2:0] FN_TX_PAND  = 3'h0;
	localparam logic [2:0] FN_TX_POR   = 3'h1;
	localparam logic [2:0] FN_TX_FV    = 3'h2;
	localparam logic [2:0] FN_TX_LV    = 3'h3;
	localparam logic [2:0] FN_TX_SYNC  = 3'h4;
	localparam logic [2:0] FN_TX_IRQ   = 3'h5;

	typedef struct packed {
		logic [3:0] remote_pins;
		logic       lock;
		logic       pass;
		logic       frame_valid;
		logic       line_valid;
		logic       enabled;
	} gofm_rx_port_s;

	typedef struct packed {
		logic pass_and;
		logic pass_or;
		logic frame_valid;
		logic line_valid;
		logic ports_synced;
		logic irq;
	} gofm_tx_port_s;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gofm_reg_req_s;

endpackage

// *** logic/gofm_pin_mux.sv ***
// Output function selection for the seven general-purpose pins
module gofm_pin_mux
	import gofm_pkg::*;
(
	input  wire logic                   ref_clk,        // 40 MHz clock
	input  wire logic                   resetn,         // Async reset, low
	input  wire gofm_reg_req_s          reg_req,        // Register access
	output logic [7:0]                  reg_rdata,      // Read data
	output logic                        reg_rvalid,     // Read data valid
	input  wire gofm_rx_port_s [1:0]    rx_port,        // Receive port status
	input  wire gofm_tx_port_s          tx_port,        // Transmit port status
	input  wire logic                   frame_sync_signal, // Frame sync
	input  wire logic                   device_irq,     // Device interrupt
	output logic [NUM_PINS-1:0]         pin_out,        // Pin output level
	output logic [NUM_PINS-1:0]         pin_oe          // Pin drive enable
);

	logic [7:0] ctl_reg [NUM_PINS];
	logic [NUM_PINS-1:0] lvl_next;
	logic [NUM_PINS-1:0] oe_next;
	logic [2:0] addr_idx;
	logic       addr_hit;

	assign addr_hit = reg_req.addr >= PIN0_CTL_OFFSET
		&& reg_req.addr <= PIN6_CTL_OFFSET;
	assign addr_idx = 3'(reg_req.addr - PIN0_CTL_OFFSET);

	// Control registers, one byte per pin
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				ctl_reg[i] <= PIN_CTL_RESET;
			end
		end else if (reg_req.write && addr_hit) begin
			ctl_reg[addr_idx] <= reg_req.wdata;
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.read;
			if (reg_req.read) begin
				reg_rdata <= addr_hit ? ctl_reg[addr_idx] : 8'h00;
			end
		end
	end

	// Aggregates over enabled ports; with none enabled all read low
	logic any_en;
	logic lock_or;
	logic lock_and;
	logic pass_and;

	always_comb begin
		any_en   = 1'b0;
		lock_or  = 1'b0;
		lock_and = 1'b1;
		pass_and = 1'b1;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (rx_port[p].enabled) begin
				any_en   = 1'b1;
				lock_or  = lock_or | rx_port[p].lock;
				lock_and = lock_and & rx_port[p].lock;
				pass_and = pass_and & rx_port[p].pass;
			end
		end
		lock_and = lock_and & any_en;
		pass_and = pass_and & any_en;
	end

	always_comb begin
		logic [2:0] fn;
		logic [2:0] src;
		logic       drv;
		logic       lvl;
		fn  = 3'h0;
		src = 3'h0;
		drv = 1'b0;
		lvl = 1'b0;
		for (int i = 0; i < NUM_PINS; i++) begin
			fn  = ctl_reg[i][FUNC_MSB:FUNC_LSB];
			src = ctl_reg[i][SRC_MSB:SRC_LSB];
			drv = 1'b1;
			lvl = 1'b0;
			case (src)
				SRC_PORT0, SRC_PORT1: begin
					case (fn)
						FN_LOCK: lvl = rx_port[src[0]].lock;
						FN_PASS: lvl = rx_port[src[0]].pass;
						FN_FV:   lvl = rx_port[src[0]].frame_valid;
						FN_LV:   lvl = rx_port[src[0]].line_valid;
						// Remote pins 0-3, and
						default: lvl = rx_port[src[0]].remote_pins[fn[1:0]];
					endcase
				end
				SRC_DEVICE: begin
					case (fn)
						FN_CONST:    lvl = ctl_reg[i][CONST_BIT];
						FN_LOCK_OR:  lvl = lock_or;
						FN_LOCK_AND: lvl = lock_and;
						FN_PASS_AND: lvl = pass_and;
						FN_FSYNC:    lvl = frame_sync_signal;
						FN_IRQ_HI:   lvl = device_irq;
						FN_IRQ_LO:   lvl = ~device_irq;
						default:     drv = 1'b0;
					endcase
				end
				SRC_TXPORT: begin
					case (fn)
						FN_TX_PAND: lvl = tx_port.pass_and;
						FN_TX_POR:  lvl = tx_port.pass_or;
						FN_TX_FV:   lvl = tx_port.frame_valid;
						FN_TX_LV:   lvl = tx_port.line_valid;
						FN_TX_SYNC: lvl = tx_port.ports_synced;
						FN_TX_IRQ:  lvl = tx_port.irq;
						default:    drv = 1'b0;
					endcase
				end
				default: drv = 1'b0;
			endcase
			// Enable bit gates everything
			oe_next[i]  = drv & ctl_reg[i][EN_BIT];
			lvl_next[i] = lvl & oe_next[i];
		end
	end

	// Registered pins cost one cycle of latency but give glitch-free pads
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else begin
			pin_out <= lvl_next;
			pin_oe  <= oe_next;
		end
	end

endmodule

// *** tb/gofm_pin_mux_properties.sv ***
// Port checker for the pin output function selector
module gofm_chk
	import gofm_pkg::*;
(
	input wire logic                ref_clk,           // Clock
	input wire logic                resetn,            // Reset
	input wire gofm_reg_req_s       reg_req,           // Bus
	input wire logic [7:0]          reg_rdata,         // Data
	input wire logic                reg_rvalid,        // Valid
	input wire gofm_rx_port_s [1:0] rx_port,           // Ports
	input wire logic                frame_sync_signal, // Sync
	input wire logic [6:0]          pin_out,           // Level
	input wire logic [6:0]          pin_oe             // Drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] c0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Shadow of pin 0 byte, so pin 0 can be tied to its setting
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			c0 <= 8'h00;
		else if (reg_req.write && reg_req.addr == 8'h10)
			c0 <= reg_req.wdata;
	end
	chk_read_answer: assert property (reg_req.read |=> reg_rvalid)
		else $error("read not answered");
	chk_undriven_low: assert property ((pin_out & ~pin_oe) == 7'h00)
		else $error("level without drive");
	chk_enable_off: assert property (!c0[0] |=> !pin_oe[0])
		else $error("pin driven while disabled");
	chk_port0_lock: assert property (c0 == 8'h81 |=>
		pin_out[0] == $past(rx_port[0].lock)) else $error("lock lost");
	chk_port1_remote: assert property (c0 == 8'h05 |=>
		pin_out[0] == $past(rx_port[1].remote_pins[0])) else $error("remote");
	chk_const_level: assert property (c0[7:2] == 6'h04 && c0[0] |=>
		pin_oe[0] && pin_out[0] == $past(c0[1])) else $error("constant");
	chk_frame_sync: assert property (c0[7:2] == 6'h24 && c0[0] |=>
		pin_out[0] == $past(frame_sync_signal)) else $error("frame sync");
	chk_reserved_src: assert property (c0[3] |=> !pin_oe[0])
		else $error("reserved source driven");
	cover property (c0 == 8'h81 ##1 pin_out[0]);
	cover property (reg_rvalid && reg_rdata != 8'h00);
	cover property (c0 == 8'h13 ##1 pin_out[0]);
endmodule

bind gofm_pin_mux gofm_chk u_chk (.ref_clk, .resetn, .reg_req, .reg_rdata,
	.reg_rvalid, .rx_port, .frame_sync_signal, .pin_out, .pin_oe);

// *** tb/tb.sv ***
// Self-checking bench for the pin output function selector
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gofm_pkg::*;
	logic                ref_clk = 0;
	logic                resetn = 0;
	gofm_reg_req_s       req = '0;
	gofm_rx_port_s [1:0] rx = '0;
	gofm_tx_port_s       tx = '0;
	logic                fs = 0;
	logic                irq = 0;
	logic [7:0]          rdata;
	logic                rvalid;
	logic [6:0]          pout, poe;
	logic [7:0]          ctl [7] = '{default: 8'h00};
	integer              seed = 62;
	int                  error_cnt = 0;
	int                  comparisons = 0;
	gofm_pin_mux dut (.ref_clk, .resetn, .reg_req(req), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .rx_port(rx), .tx_port(tx),
		.frame_sync_signal(fs), .device_irq(irq), .pin_out(pout), .pin_oe(poe));
	always #12.5 ref_clk = ~ref_clk;
	task automatic check(string n, logic [7:0] s, logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Returns {drive, level}; reserved codes give an undriven, low pin
	function automatic logic [1:0] mdl(logic [7:0] c);
		logic [2:0] f;
		logic [5:0] t;
		logic [1:0] lk, pa, en;
		logic [3:0] w;
		logic [7:0] d;
		f = c[7:5];
		t = tx;
		lk = {rx[1].lock, rx[0].lock};
		pa = {rx[1].pass, rx[0].pass};
		en = {rx[1].enabled, rx[0].enabled};
		w = {rx[c[2]].lock, rx[c[2]].pass, rx[c[2]].frame_valid,
			rx[c[2]].line_valid};
		d = {c[1], |(lk & en), en != 0 && &(lk | ~en),
			en != 0 && &(pa | ~en), fs, irq, !irq, 1'b0};
		if (!c[0] || c[3])
			return 2'b00;
		if (c[4:2] < 3'h2)
			return {1'b1, f[2] ? w[3 - f[1:0]] : rx[c[2]].remote_pins[f[1:0]]};
		if (c[4:2] == 3'h4 && f != 3'h7)
			return {1'b1, d[7 - f]};
		if (c[4:2] == 3'h5 && f < 3'h6)
			return {1'b1, t[5 - f]};
		return 2'b00;
	endfunction
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		req <= '0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge ref_clk);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk);
		req <= '0;
		#1;
		check("reg_rvalid", {7'h00, rvalid}, 8'h01);
		check("reg_rdata", rdata, e);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(8'h10 + 8'(i), 8'h00);
		wr(8'h0F, 8'hFF);
		wr(8'h17, 8'hFF);
		rd(8'h0F, 8'h00);
		rd(8'h17, 8'h00);
		$display("test registers done");
		// Every byte value passes through pin 0; the others get random bytes
		for (int b = 0; b < 256; b++) begin
			@(posedge ref_clk);
			rx <= 18'($random(seed));
			tx <= 6'($random(seed));
			{fs, irq} <= 2'($random(seed));
			ctl[0] = b[7:0];
			ctl[b % 6 + 1] = 8'($random(seed));
			// Port enable bits are randomised here along with the rest of rx
			wr(8'h10, ctl[0]);
			wr(8'h11 + 8'(b % 6), ctl[b % 6 + 1]);
			repeat (2) @(posedge ref_clk);
			#1;
			for (int p = 0; p < 7; p++)
				check("pin", {6'h00, poe[p], pout[p]}, {6'h00, mdl(ctl[p])});
		end
		for (int i = 0; i < 7; i++)
			rd(8'h10 + 8'(i), ctl[i]);
		$display("test functions done");
		stop_test();
	end
	initial begin
		#100us;
		error_cnt++;
		stop_test();
	end
endmodule
